// *** pkg/speed_sel_defs.vh ***
`ifndef SPEED_SEL_DEFS_VH
`define SPEED_SEL_DEFS_VH
// Reference source codes.
`define REF_SRC_PANEL   3'h0
`define REF_SRC_ANALOG  3'h1
`define REF_SRC_SERIAL  3'h2
`define REF_SRC_OPTION  3'h3
`define REF_SRC_PULSE   3'h4
`define REF_SRC_RESET   3'h1
// Run source codes.
`define RUN_SRC_PANEL   2'h0
`define RUN_SRC_TERM    2'h1
`define RUN_SRC_SERIAL  2'h2
`define RUN_SRC_OPTION  2'h3
`define RUN_SRC_RESET   2'h1
// Digital input function codes.
`define DIN_FN_STEP1    8'h03
`define DIN_FN_STEP2    8'h04
`define DIN_FN_STEP3    8'h05
`define DIN_FN_JOG      8'h06
// Second analog input function codes.
`define AIN2_FN_ADD     8'h00
`define AIN2_FN_AUX     8'h02
`define AIN2_FN_UNUSED  8'h1F
// Pulse input function code for frequency reference.
`define PULSE_FN_FREF   2'h0
// Pulse scale reset value in Hz.
`define PULSE_SCALE_RESET 16'h05A0
// Full scale reference value (100 percent).
`define REF_FULL        16'h2710
// One control cycle of the pulse counter gate, in cycles of 100 MHz (1 s gate).
`define GATE_TIME_MS    1000
`define GATE_CYCLES     (`GATE_TIME_MS * 100000)
// Register offsets.
`define REG_REF_SRC     8'h00
`define REG_RUN_SRC     8'h04
`define REG_AIN_CFG     8'h08
`define REG_PULSE_CFG   8'h0C
`define REG_DIN_FN      8'h10
`define REG_STATUS      8'h14
`define REG_SEL_REF     8'h18
`define REG_PULSE_HZ    8'h1C
`define REG_TABLE_BASE  8'h40
`define REG_TABLE_LAST  8'h80
`endif

// *** src/ref_table_mem.v ***
`timescale 1ns/1ns
`default_nettype none
module ref_table_mem
#(
  parameter WIDTH = 16,
  parameter DEPTH = 17,
  parameter AW    = 5
)
(
  input  wire             clock_i,
  input  wire             wr_en_i,
  input  wire [AW-1:0]    wr_addr_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire [AW-1:0]    rd_addr_i,
  output reg  [WIDTH-1:0] rd_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Stored references are written by software and read out through a register.
  always @(posedge clock_i)
  begin
    if (wr_en_i && (wr_addr_i < DEPTH))
      mem[wr_addr_i] <= wr_data_i;
    if (rd_addr_i < DEPTH)
      rd_data_o <= mem[rd_addr_i];
    else
      rd_data_o <= {WIDTH{1'b0}};
  end
endmodule
`default_nettype wire

// *** src/pulse_freq_meter.v ***
`timescale 1ns/1ns
`default_nettype none
module pulse_freq_meter
#(
  parameter GATE_CYCLES = 100000000
)
(
  input  wire        clock_i,
  input  wire        rst_b_i,
  input  wire        pulse_i,
  output reg  [15:0] freq_hz_o
);
  reg [31:0] gate_q;
  reg [15:0] count_q;
  reg        last_q;
  wire       gate_end;
  wire       rise;

  // Gate end marks one second of clock; rise marks a pulse edge.
  assign gate_end = (gate_q == GATE_CYCLES - 1);
  assign rise     = pulse_i & ~last_q;

  // Count rising edges across each gate and latch the total as hertz.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gate_q    <= 32'h0000_0000;
      count_q   <= 16'h0000;
      last_q    <= 1'b0;
      freq_hz_o <= 16'h0000;
    end
    else
    begin
      last_q <= pulse_i;
      if (gate_end)
      begin
        gate_q    <= 32'h0000_0000;
        freq_hz_o <= count_q;
        count_q   <= {15'h0000, rise};
      end
      else
      begin
        gate_q <= gate_q + 32'h0000_0001;
        if (rise && (count_q != 16'hFFFF))
          count_q <= count_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/speed_reference_selector.v ***
// Notes on behaviour
// - The reference source code means 0 panel, 1 analog, 2 serial, 3 option card, 4 pulse train, legal 0 to 4.
// - Source 4 takes the reference from the pulse train input.
// - Pulse referencing needs pulse function 0 and scales so the configured pulse rate is 100 percent.
// - With source 1 the second analog input, as a 4 to 20 mA current, is accepted as reference.
// - With second input function 0 the second analog value is added to the first.
// - With the swap bit set the second analog input is master and the first auxiliary.
// - In master/auxiliary mode step bit one off picks the first input and on picks the second.
// - The first analog input voltage range comes from its range selection.
// - Up to 9 speeds exist: 8 stored references reached by the step bits and one jog reference.
// - Input function 3, 4, 5 and 6 give step bits one, two, three and jog selection.
// - Step bits one to three form an index whose values 0 to 7 pick stored references one to eight.
// - Jog selection on uses the jog reference whatever the step bits are.
// - Step one uses the first analog input with source 1 and stored reference one with source 0.
// - Step two uses the second analog input with function 2 and stored reference two with function 1F.
// - With second input function 2, step bit one also switches master and auxiliary.
// - Run commands come from 0 panel, 1 terminals, 2 serial, 3 option card, default 1.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "speed_sel_defs.vh"
module speed_reference_selector
#(
  parameter RW          = 16,
  parameter GATE_CYCLES = `GATE_CYCLES
)
(
  input  wire          clock_i,
  input  wire          rst_b_i,
  input  wire [7:0]    addr_i,
  input  wire [31:0]   wdata_i,
  input  wire          wr_i,
  input  wire          rd_i,
  output reg  [31:0]   rdata_o,
  input  wire [RW-1:0] analog_in_first_i,
  input  wire [RW-1:0] analog_in_second_i,
  input  wire          pulse_train_in_i,
  input  wire          din_four_i,
  input  wire          din_five_i,
  input  wire          din_six_i,
  input  wire          din_seven_i,
  input  wire [RW-1:0] panel_ref_i,
  input  wire [RW-1:0] serial_ref_i,
  input  wire [RW-1:0] option_ref_i,
  input  wire [1:0]    panel_run_i,
  input  wire [1:0]    term_run_i,
  input  wire [1:0]    serial_run_i,
  input  wire [1:0]    option_run_i,
  output reg  [RW-1:0] freq_ref_o,
  output reg  [1:0]    run_cmd_o,
  output reg  [1:0]    ain1_range_o,
  output reg           ref_src_err_o
);
  reg  [2:0]    ref_source_sel_q;
  reg  [1:0]    run_source_sel_q;
  reg  [1:0]    ain1_range_sel_q;
  reg  [7:0]    ain2_function_sel_q;
  reg           ain_swap_sel_q;
  reg  [1:0]    pulse_in_function_q;
  reg  [15:0]   pulse_in_scale_q;
  reg  [7:0]    din4_function_q;
  reg  [7:0]    din5_function_q;
  reg  [7:0]    din6_function_q;
  reg  [7:0]    din7_function_q;
  reg  [4:0]    tbl_raddr_q;
  reg  [RW-1:0] ref_d;
  wire [15:0]   pulse_hz;
  wire [RW-1:0] tbl_data;
  wire [RW-1:0] tbl_raw;
  wire          tbl_fresh;
  wire          tbl_hit;
  wire          tbl_wr;
  wire [4:0]    tbl_waddr;
  wire          step1;
  wire          step2;
  wire          step3;
  wire          jog;
  wire [2:0]    step_idx;
  wire [4:0]    tbl_raddr;
  wire [RW-1:0] master;
  wire [RW-1:0] aux;
  wire [RW:0]   ana_sum;
  wire [31:0]   pulse_prod;
  wire [31:0]   pulse_ref;

  // A terminal is on when its function code matches and its level is high.
  // A terminal whose code names no function here simply plays no part in the selection.
  function fn_on;
    input [7:0] fn;
    input [7:0] code;
    input       lvl;
    begin
      fn_on = (fn == code) & lvl;
    end
  endfunction

  // Clamp a wide value to the reference width.
  // Sums and scaled pulse rates can exceed full scale, and wrapping would invert the speed.
  function [RW-1:0] sat;
    input [31:0] v;
    begin
      if (v > {{(32-RW){1'b0}}, {RW{1'b1}}})
        sat = {RW{1'b1}};
      else
        sat = v[RW-1:0];
    end
  endfunction

  // Terminal function decode on all four multi-function inputs.
  // Two terminals given the same function act as a wired OR of that function.
  assign step1 = fn_on(din4_function_q, `DIN_FN_STEP1, din_four_i) |
                 fn_on(din5_function_q, `DIN_FN_STEP1, din_five_i) |
                 fn_on(din6_function_q, `DIN_FN_STEP1, din_six_i) |
                 fn_on(din7_function_q, `DIN_FN_STEP1, din_seven_i);
  assign step2 = fn_on(din4_function_q, `DIN_FN_STEP2, din_four_i) |
                 fn_on(din5_function_q, `DIN_FN_STEP2, din_five_i) |
                 fn_on(din6_function_q, `DIN_FN_STEP2, din_six_i) |
                 fn_on(din7_function_q, `DIN_FN_STEP2, din_seven_i);
  assign step3 = fn_on(din4_function_q, `DIN_FN_STEP3, din_four_i) |
                 fn_on(din5_function_q, `DIN_FN_STEP3, din_five_i) |
                 fn_on(din6_function_q, `DIN_FN_STEP3, din_six_i) |
                 fn_on(din7_function_q, `DIN_FN_STEP3, din_seven_i);
  assign jog   = fn_on(din4_function_q, `DIN_FN_JOG, din_four_i) |
                 fn_on(din5_function_q, `DIN_FN_JOG, din_five_i) |
                 fn_on(din6_function_q, `DIN_FN_JOG, din_six_i) |
                 fn_on(din7_function_q, `DIN_FN_JOG, din_seven_i);

  // Binary step index; jog occupies the last table entry and wins over the steps.
  // Step bit one is the least significant bit of the index.
  assign step_idx  = {step3, step2, step1};
  assign tbl_raddr = jog ? 5'h10 : {2'b00, step_idx};

  // The table read port is registered, so its word belongs to the address of the last cycle.
  // Until the word for the present address arrives the reference holds its old value, so a
  // terminal change never lets a neighbouring stored entry reach the output for a cycle.
  assign tbl_fresh = (tbl_raddr_q == tbl_raddr);
  assign tbl_data  = tbl_fresh ? tbl_raw : freq_ref_o;

  // Address of the word now standing on the table read port.
  // It resets to the first entry, matching the address that idle terminals select.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tbl_raddr_q <= 5'h00;
    else
      tbl_raddr_q <= tbl_raddr;
  end

  // Master and auxiliary analog channels, swappable.
  // The sum keeps a carry bit so that saturation, not wrap-around, handles an overflow.
  assign master  = ain_swap_sel_q ? analog_in_second_i : analog_in_first_i;
  assign aux     = ain_swap_sel_q ? analog_in_first_i : analog_in_second_i;
  assign ana_sum = {1'b0, master} + {1'b0, aux};

  // Pulse rate scaled so that the configured rate gives the full scale reference.
  // The rate is a whole count per gate, so the reference moves in steps of one hertz of input.
  assign pulse_prod = {16'h0000, pulse_hz} * {16'h0000, `REF_FULL};
  assign pulse_ref  = pulse_prod / {16'h0000, pulse_in_scale_q};

  // Software table writes land in the reference memory. Only the seventeen words from the base
  // up to the jog entry are mapped; the index below wraps every 128 bytes, so without the upper
  // bound a write high in the map would land on a stored reference.
  assign tbl_hit   = (addr_i >= `REG_TABLE_BASE) && (addr_i <= `REG_TABLE_LAST);
  assign tbl_wr    = wr_i && tbl_hit && (addr_i[1:0] == 2'b00);
  assign tbl_waddr = addr_i[6:2] - 5'h10;

  // Seventeen stored words: sixteen step entries, of which the step index reaches the first eight, and the jog speed in the last word.
  ref_table_mem #(
    .WIDTH (RW),
    .DEPTH (17),
    .AW    (5)
  ) u_tbl (
    .clock_i   (clock_i),
    .wr_en_i   (tbl_wr),
    .wr_addr_i (tbl_waddr),
    .wr_data_i (wdata_i[RW-1:0]),
    .rd_addr_i (tbl_raddr),
    .rd_data_o (tbl_raw)
  );

  // Measures the pulse input rate in hertz once per gate.
  pulse_freq_meter #(
    .GATE_CYCLES (GATE_CYCLES)
  ) u_pulse (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .pulse_i   (pulse_train_in_i),
    .freq_hz_o (pulse_hz)
  );

  // Reference selection from the current source and terminal states.
  // Serial and option sources pass straight through; an illegal source code holds the last
  // reference rather than dropping the speed to zero.
  always @*
  begin
    ref_d = freq_ref_o;
    case (ref_source_sel_q)
      `REF_SRC_PANEL:
      begin
        ref_d = panel_ref_i;
        if (jog || (step_idx != 3'h0))
          ref_d = tbl_data;
        else
          ref_d = tbl_data;
      end
      `REF_SRC_ANALOG:
      begin
        if (jog)
          ref_d = tbl_data;
        else if (ain2_function_sel_q == `AIN2_FN_AUX)
        begin
          if (step_idx == 3'h0)
            ref_d = master;
          else if (step_idx == 3'h1)
            ref_d = aux;
          else
            ref_d = tbl_data;
        end
        else if (ain2_function_sel_q == `AIN2_FN_ADD)
        begin
          if (step_idx == 3'h0)
            ref_d = sat({{(31-RW){1'b0}}, ana_sum});
          else
            ref_d = tbl_data;
        end
        else
        begin
          if (step_idx == 3'h0)
            ref_d = master;
          else
            ref_d = tbl_data;
        end
      end
      `REF_SRC_SERIAL: ref_d = serial_ref_i;
      `REF_SRC_OPTION: ref_d = option_ref_i;
      `REF_SRC_PULSE:
      begin
        if (pulse_in_function_q == `PULSE_FN_FREF)
          ref_d = sat(pulse_ref);
        else
          ref_d = {RW{1'b0}};
      end
      default: ref_d = freq_ref_o;
    endcase
  end

  // Outputs updated every control cycle from the live selection.
  // Run inputs are passed through untouched; start and stop sequencing happens downstream.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      freq_ref_o    <= {RW{1'b0}};
      run_cmd_o     <= 2'b00;
      ain1_range_o  <= 2'b00;
      ref_src_err_o <= 1'b0;
    end
    else
    begin
      freq_ref_o    <= ref_d;
      ain1_range_o  <= ain1_range_sel_q;
      ref_src_err_o <= (ref_source_sel_q > `REF_SRC_PULSE);
      case (run_source_sel_q)
        `RUN_SRC_PANEL:  run_cmd_o <= panel_run_i;
        `RUN_SRC_TERM:   run_cmd_o <= term_run_i;
        `RUN_SRC_SERIAL: run_cmd_o <= serial_run_i;
        default:         run_cmd_o <= option_run_i;
      endcase
    end
  end

  // Register writes and read data one cycle after the read strobe.
  // A pulse scale of zero is refused because the pulse path divides by it.
  // The status word shows the decoded terminal functions, not the raw terminal levels.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_source_sel_q    <= `REF_SRC_RESET;
      run_source_sel_q    <= `RUN_SRC_RESET;
      ain1_range_sel_q    <= 2'b00;
      ain2_function_sel_q <= `AIN2_FN_ADD;
      ain_swap_sel_q      <= 1'b0;
      pulse_in_function_q <= `PULSE_FN_FREF;
      pulse_in_scale_q    <= `PULSE_SCALE_RESET;
      din4_function_q     <= `DIN_FN_STEP1;
      din5_function_q     <= `DIN_FN_STEP2;
      din6_function_q     <= `DIN_FN_STEP3;
      din7_function_q     <= `DIN_FN_JOG;
      rdata_o             <= 32'h0000_0000;
    end
    else
    begin
      rdata_o  <= 32'h0000_0000;
      if (wr_i)
      begin
        if (addr_i == `REG_REF_SRC)
          ref_source_sel_q <= wdata_i[2:0];
        else if (addr_i == `REG_RUN_SRC)
          run_source_sel_q <= wdata_i[1:0];
        else if (addr_i == `REG_AIN_CFG)
        begin
          ain1_range_sel_q    <= wdata_i[1:0];
          ain_swap_sel_q      <= wdata_i[4];
          ain2_function_sel_q <= wdata_i[15:8];
        end
        else if (addr_i == `REG_PULSE_CFG)
        begin
          pulse_in_function_q <= wdata_i[1:0];
          if (wdata_i[31:16] != 16'h0000)
            pulse_in_scale_q <= wdata_i[31:16];
        end
        else if (addr_i == `REG_DIN_FN)
        begin
          din4_function_q <= wdata_i[7:0];
          din5_function_q <= wdata_i[15:8];
          din6_function_q <= wdata_i[23:16];
          din7_function_q <= wdata_i[31:24];
        end
      end
      if (rd_i)
      begin
        if (addr_i == `REG_REF_SRC)
          rdata_o <= {29'h0000_0000, ref_source_sel_q};
        else if (addr_i == `REG_RUN_SRC)
          rdata_o <= {30'h0000_0000, run_source_sel_q};
        else if (addr_i == `REG_AIN_CFG)
          rdata_o <= {16'h0000, ain2_function_sel_q, 3'h0, ain_swap_sel_q, 2'h0, ain1_range_sel_q};
        else if (addr_i == `REG_PULSE_CFG)
          rdata_o <= {pulse_in_scale_q, 14'h0000, pulse_in_function_q};
        else if (addr_i == `REG_DIN_FN)
          rdata_o <= {din7_function_q, din6_function_q, din5_function_q, din4_function_q};
        else if (addr_i == `REG_STATUS)
          rdata_o <= {27'h0000_000, ref_src_err_o, jog, step3, step2, step1};
        else if (addr_i == `REG_SEL_REF)
          rdata_o <= {{(32-RW){1'b0}}, freq_ref_o};
        else if (addr_i == `REG_PULSE_HZ)
          rdata_o <= {16'h0000, pulse_hz};
      end
    end
  end
endmodule
`default_nettype wire

// *** test/speed_sel_props.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "speed_sel_defs.vh"
module speed_sel_props
#(
  parameter RW = 16
)
(
  input wire logic          clock_i,
  input wire logic          rst_b_i,
  input wire logic [7:0]    addr_i,
  input wire logic [31:0]   wdata_i,
  input wire logic          wr_i,
  input wire logic [RW-1:0] analog_in_first_i,
  input wire logic [RW-1:0] analog_in_second_i,
  input wire logic          din_four_i,
  input wire logic          din_five_i,
  input wire logic          din_six_i,
  input wire logic          din_seven_i,
  input wire logic [RW-1:0] serial_ref_i,
  input wire logic [1:0]    panel_run_i,
  input wire logic [1:0]    term_run_i,
  input wire logic [1:0]    serial_run_i,
  input wire logic [1:0]    option_run_i,
  input wire logic [RW-1:0] freq_ref_o,
  input wire logic [1:0]    run_cmd_o,
  input wire logic [1:0]    ain1_range_o,
  input wire logic          ref_src_err_o
);
  logic [2:0]    src_q;
  logic [1:0]    run_q;
  logic [15:0]   cfg_q;
  logic [RW-1:0] ref1_q;
  logic [RW-1:0] jog_q;
  logic [RW:0]   sum_w;
  logic [RW-1:0] ma_w;
  logic [1:0]    run_w;
  logic          quiet_w;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Shadows the steering registers and the two table entries that are checked.
  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      src_q <= `REF_SRC_RESET;
      run_q <= `RUN_SRC_RESET;
      cfg_q <= 16'h0000;
      ref1_q <= '0;
      jog_q <= '0;
    end
    else if (wr_i)
    begin
      if (addr_i == `REG_REF_SRC) src_q <= wdata_i[2:0];
      if (addr_i == `REG_RUN_SRC) run_q <= wdata_i[1:0];
      if (addr_i == `REG_AIN_CFG) cfg_q <= wdata_i[15:0];
      if (addr_i == `REG_TABLE_BASE) ref1_q <= wdata_i[RW-1:0];
      if (addr_i == 8'h80) jog_q <= wdata_i[RW-1:0];
    end
  // Expected values of the analog and run command paths.
  assign sum_w = {1'b0, analog_in_first_i} + {1'b0, analog_in_second_i};
  assign ma_w = (din_four_i ^ cfg_q[4]) ? analog_in_second_i : analog_in_first_i;
  assign run_w = run_q[1] ? (run_q[0] ? option_run_i : serial_run_i) : (run_q[0] ? term_run_i : panel_run_i);
  assign quiet_w = !din_five_i && !din_six_i && !din_seven_i;
  sequence jog_held;
    (src_q == `REF_SRC_PANEL && din_seven_i) [*3];
  endsequence
  sequence step_one_held;
    (src_q == `REF_SRC_PANEL && !din_four_i && quiet_w) [*3];
  endsequence
  src_err_a: assert property ($stable(src_q) |-> ref_src_err_o == (src_q > 3'h4))
    else $error("reference source error flag wrong");
  range_copy_a: assert property ($stable(cfg_q[1:0]) |-> ain1_range_o == cfg_q[1:0])
    else $error("first input range output wrong");
  run_select_a: assert property (1'b1 |=> run_cmd_o == $past(run_w))
    else $error("run command from wrong source");
  serial_pass_a: assert property (src_q == `REF_SRC_SERIAL |=> freq_ref_o == $past(serial_ref_i))
    else $error("serial reference not passed");
  master_aux_a: assert property (src_q == 3'h1 && cfg_q[15:8] == `AIN2_FN_AUX && quiet_w
    |=> freq_ref_o == $past(ma_w)) else $error("master or auxiliary pick wrong");
  analog_sum_a: assert property (src_q == 3'h1 && cfg_q[15:8] == `AIN2_FN_ADD && !din_four_i && quiet_w
    && !sum_w[RW] |=> {1'b0, freq_ref_o} == $past(sum_w)) else $error("analog sum wrong");
  jog_priority_a: assert property (jog_held |=> freq_ref_o == jog_q)
    else $error("jog reference not selected");
  step_one_a: assert property (step_one_held |=> freq_ref_o == ref1_q)
    else $error("stored reference one not selected");
endmodule
bind speed_reference_selector speed_sel_props #(.RW(RW)) props
(
  .clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .analog_in_first_i, .analog_in_second_i,
  .din_four_i, .din_five_i, .din_six_i, .din_seven_i, .serial_ref_i, .panel_run_i, .term_run_i,
  .serial_run_i, .option_run_i, .freq_ref_o, .run_cmd_o, .ain1_range_o, .ref_src_err_o
);
`default_nettype wire

// *** test/terminal_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module terminal_model
(
  input  wire logic       clock_i,
  input  wire logic       pulse_en_i,
  input  wire logic [3:0] step_i,
  output var  logic       pulse_o,
  output var  logic [3:0] din_o
);
  logic [1:0] phase_q;
  // Contacts close one cycle after asked; the pulse train stands low while disabled.
  always_ff @(posedge clock_i)
  begin
    din_o <= step_i;
    phase_q <= pulse_en_i ? phase_q + 2'h1 : 2'h0;
    pulse_o <= pulse_en_i & ~phase_q[1];
  end
endmodule
`default_nettype wire

// *** test/speed_reference_selector_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "speed_sel_defs.vh"
module speed_reference_selector_tb;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] a1 = 16'h0000;
  logic [15:0] a2 = 16'h0000;
  logic [15:0] sref = 16'h0000;
  logic [15:0] oref = 16'h0000;
  logic [7:0]  runv = 8'hE4;
  logic [3:0]  step = 4'h0;
  logic        pen = 1'b0;
  logic        pulse;
  logic [3:0]  din;
  logic [15:0] freq;
  logic [1:0]  run;
  logic [1:0]  rng;
  logic        err;
  int          cyc = 0;
  int          bad_count = 0;
  int          check_count = 0;
  int          i;
  speed_reference_selector #(.GATE_CYCLES(100)) dut
  (
    .clock_i, .rst_b_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .analog_in_first_i(a1), .analog_in_second_i(a2), .pulse_train_in_i(pulse),
    .din_four_i(din[0]), .din_five_i(din[1]), .din_six_i(din[2]), .din_seven_i(din[3]),
    .panel_ref_i(16'h0000), .serial_ref_i(sref), .option_ref_i(oref), .panel_run_i(runv[1:0]),
    .term_run_i(runv[3:2]), .serial_run_i(runv[5:4]), .option_run_i(runv[7:6]), .freq_ref_o(freq),
    .run_cmd_o(run), .ain1_range_o(rng), .ref_src_err_o(err)
  );
  terminal_model far (.clock_i, .pulse_en_i(pen), .step_i(step), .pulse_o(pulse), .din_o(din));
  always #5 clock_i = ~clock_i;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  // Sets the terminals and compares the reference once the lookup has settled.
  task automatic fr(input logic [3:0] s, input logic [15:0] e, input string nm);
    @(posedge clock_i);
    step <= s;
    repeat (5) @(posedge clock_i);
    #1 chk(nm, {16'h0000, freq}, {16'h0000, e});
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  // Cuts a hung run short.
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rdc(`REG_REF_SRC, 32'h0000_0001, "ref source");
    rdc(`REG_RUN_SRC, 32'h0000_0001, "run source");
    rdc(`REG_DIN_FN, 32'h0605_0403, "input functions");
    rdc(8'hFC, 32'h0000_0000, "unmapped");
    done("reset");
    for (i = 0; i < 17; i++)
      wrr(`REG_TABLE_BASE + 8'(4 * i), {16'h0000, 16'h0100 + i[15:0]});
    wrr(`REG_REF_SRC, 32'h0000_0000);
    wrr(8'hC0, 32'h0000_BEEF);
    for (i = 0; i < 8; i++)
      fr(i[3:0], 16'h0100 + i[15:0], "stored");
    fr(4'h8, 16'h0110, "jog");
    fr(4'hF, 16'h0110, "jog over steps");
    rdc(`REG_STATUS, 32'h0000_000F, "status terminals");
    rdc(`REG_SEL_REF, 32'h0000_0110, "selected reference");
    done("steps");
    for (i = 0; i < 8; i++)
    begin
      if (i == 4)
        runv <= 8'h1B;
      wrr(`REG_RUN_SRC, i % 4);
      repeat (2) @(posedge clock_i);
      #1 chk("run command", {30'h0, run}, (i < 4) ? i : 7 - i);
    end
    done("run sources");
    sref <= 16'h1234;
    oref <= 16'h4321;
    wrr(`REG_REF_SRC, 32'h0000_0002);
    fr(4'h0, 16'h1234, "serial");
    wrr(`REG_REF_SRC, 32'h0000_0003);
    fr(4'h0, 16'h4321, "option");
    wrr(`REG_REF_SRC, 32'h0000_0005);
    repeat (3) @(posedge clock_i);
    #1 chk("source error", {31'h0, err}, 32'h0000_0001);
    done("sources");
    a1 <= 16'h1000;
    a2 <= 16'h0200;
    wrr(`REG_REF_SRC, 32'h0000_0001);
    fr(4'h0, 16'h1200, "sum");
    wrr(`REG_AIN_CFG, 32'h0000_0202);
    fr(4'h0, 16'h1000, "master");
    fr(4'h1, 16'h0200, "auxiliary");
    chk("range", {30'h0, rng}, 32'h0000_0002);
    wrr(`REG_AIN_CFG, 32'h0000_0210);
    fr(4'h0, 16'h0200, "swapped");
    wrr(`REG_AIN_CFG, 32'h0000_1F00);
    fr(4'h0, 16'h1000, "step one analog");
    fr(4'h1, 16'h0101, "step two stored");
    done("analog");
    wrr(`REG_PULSE_CFG, 32'h0019_0000);
    wrr(`REG_REF_SRC, 32'h0000_0004);
    pen <= 1'b1;
    repeat (300) @(posedge clock_i);
    rdc(`REG_PULSE_HZ, 32'h0000_0019, "pulse rate");
    chk("pulse full scale", {16'h0000, freq}, {16'h0000, `REF_FULL});
    wrr(`REG_PULSE_CFG, 32'h0019_0001);
    fr(4'h0, 16'h0000, "pulse other use");
    done("pulse");
    end_of_test;
  end
endmodule
`default_nettype wire
